//--- rtl/wdrc_pkg.sv
// Contract
// - watchdog reset sets flag; software, power-on or bus reset clears
// - reset enable low: timeout leaves flag alone
// - writing reset enable arms watchdog reset
// - restart bit clears count, self-clears
// - timeout: irq if enabled, reset 512 clocks later
// - external reset: control pattern 0x0x0xx0
// - flag one on watchdog, zero on power resets
// - external reset keeps watchdog reset flag
// - power-on sets power flag, clears enable
// - protected bits writable only in open window
// - upper three irq enable bits read one
// - irq enable bit four gates watchdog irq
// - priority bit selects watchdog irq level
// - machine cycle is four system clocks
// - unlock with 0xaa then 0x55, three cycles
// - timeout sets irq flag; software clears it
package wdrc_pkg;
   // register byte addresses on the wishbone bus
   localparam logic [7:0] WDRC_ADDR_CLOCK_CONTROL = 8'h8e;
   localparam logic [7:0] WDRC_ADDR_UNLOCK        = 8'hc7;
   localparam logic [7:0] WDRC_ADDR_WD_CONTROL    = 8'hd8;
   localparam logic [7:0] WDRC_ADDR_IRQ_ENABLE    = 8'he8;
   localparam logic [7:0] WDRC_ADDR_IRQ_PRIORITY  = 8'hf8;
   localparam logic [7:0] WDRC_ADDR_EVT_STATUS    = 8'hf0;
   localparam logic [7:0] WDRC_ADDR_EVT_MASK      = 8'hf4;
   // watchdog control bit positions
   localparam int WDRC_BIT_POWER_FLAG = 6;
   localparam int WDRC_BIT_IRQ_FLAG   = 3;
   localparam int WDRC_BIT_RESET_FLAG = 2;
   localparam int WDRC_BIT_RESET_EN   = 1;
   localparam int WDRC_BIT_RESTART    = 0;
   // irq enable / priority bit position
   localparam int WDRC_BIT_WD_IRQ     = 4;
   // interval select position in clock control
   localparam int WDRC_BIT_INTERVAL   = 6;
   // unlock key bytes
   localparam logic [7:0] WDRC_KEY_FIRST  = 8'haa;
   localparam logic [7:0] WDRC_KEY_SECOND = 8'h55;
   // reset values
   localparam logic [7:0] WDRC_RST_CLOCK_CONTROL = 8'h01;
   localparam logic [7:0] WDRC_RST_IRQ_ENABLE    = 8'he0;
   localparam logic [7:0] WDRC_RST_IRQ_PRIORITY  = 8'h00;
   localparam logic [7:0] WDRC_EXT_RST_KEEP_MASK = 8'h56;
   // timing
   localparam int WDRC_CLKS_PER_MCYCLE = 4;
   localparam int WDRC_WINDOW_MCYCLES  = 3;
   localparam int WDRC_WINDOW_CLKS     = WDRC_CLKS_PER_MCYCLE * WDRC_WINDOW_MCYCLES;
   localparam int WDRC_RESET_DELAY_CLKS = 512;
   localparam int WDRC_RESET_HOLD_CLKS  = 2 * WDRC_CLKS_PER_MCYCLE;
   // interval exponents: 2^17, 2^20, 2^23, 2^26
   localparam int WDRC_INTERVAL_BASE = 17;
   localparam int WDRC_INTERVAL_STEP = 3;
   // event status bits
   localparam int WDRC_EVT_TIMEOUT = 0;
   localparam int WDRC_EVT_RESET   = 1;
   // reset source carrier
   typedef struct packed {
      logic power_on;
      logic external;
   } wdrc_rst_src_type;
endpackage : wdrc_pkg

//--- rtl/wdrc_top.sv
`timescale 1ns/1ps
`default_nettype none
module wdrc_top
   import wdrc_pkg::*;
#(
   parameter int CNT_W    = 26,                 // longest interval 2^26
   parameter int IVL_BASE = WDRC_INTERVAL_BASE  // exponent of the shortest interval
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,         // bus/logic reset
   input  wire wdrc_rst_src_type  src_i,         // power-on / external reset requests
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [7:0]        adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic       [31:0]      dat_o,
   output logic                   ack_o,
   output logic                   wd_irq_o,      // watchdog irq request
   output logic                   wd_irq_high_o, // priority level of request
   output logic                   wd_reset_o,    // device reset from watchdog
   output logic                   irq_o          // masked event interrupt
);
   logic [7:0]       clock_control;        // interval select lives in bits 7:6
   logic [7:0]       watchdog_control;
   logic [7:0]       extended_irq_enable;
   logic [7:0]       extended_irq_priority;
   logic [1:0]       evt_status;
   logic [1:0]       evt_mask;
   logic [CNT_W-1:0] wd_count;             // free running watchdog count
   logic [9:0]       delay_cnt;            // counts toward forced reset
   logic             delay_run;
   logic [3:0]       hold_cnt;             // reset hold length
   logic [1:0]       mcycle;               // state c1..c4
   logic             key_seen;             // first key written last access
   logic [3:0]       window_cnt;           // clocks left in open window
   logic             timeout;
   logic             wd_fire;
   logic             wr_stb;
   logic             rd_stb;
   logic [7:0]       wr_byte;
   logic             window_open;
   logic [1:0]       sel_interval;
   logic [4:0]       expo;

   // bus decode
   // one wait state: ack one cycle after request, dropped next cycle
   // the request is taken on the edge that raises ack, so a master that
   // holds cyc and stb until it sees ack never gets a second strobe here
   // only byte lane 0 carries data; other lanes read back zero
   assign wr_stb  = cyc_i && stb_i && we_i && !ack_o;
   assign rd_stb  = cyc_i && stb_i && !we_i && !ack_o;
   assign wr_byte = sel_i[0] ? dat_i[7:0] : 8'h00;
   assign window_open = (window_cnt != 4'h0);
   assign sel_interval = clock_control[WDRC_BIT_INTERVAL+1:WDRC_BIT_INTERVAL];
   // a smaller base shortens simulation, and below 9 starves the reset at the shortest interval; the interval steps stay at three
   assign expo = 5'(IVL_BASE + WDRC_INTERVAL_STEP * int'(sel_interval));
   // timeout when selected count bit pattern reached all ones
   assign timeout = (wd_count[expo-5'd1 -: 1] == 1'b1) &&
                    ((wd_count & ((CNT_W'(1) << expo) - CNT_W'(1))) ==
                     ((CNT_W'(1) << expo) - CNT_W'(1)));
   assign wd_fire = delay_run && (delay_cnt == 10'(WDRC_RESET_DELAY_CLKS - 1));

   // machine cycle phase, four states per cycle
   // the phase counter is kept for the state sequence only; bus timing
   // does not wait on it, which trades cycle accuracy for a short ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mcycle <= 2'd0;
      end else begin
         mcycle <= mcycle + 2'd1;
      end
   end

   // wishbone ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   // unlock sequence: 0xaa then 0x55 as consecutive accesses
   // any other access between the keys drops the first key, so stray
   // software cannot open the window by chance
   // a forced reset also closes the window
   always_ff @(posedge clk_i) begin
      if (rst_i || wd_reset_o) begin
         key_seen   <= 1'b0;
         window_cnt <= 4'h0;
      end else begin
         if (window_cnt != 4'h0) begin
            window_cnt <= window_cnt - 4'h1;
         end
         if (wr_stb && adr_i == WDRC_ADDR_UNLOCK) begin
            key_seen <= (wr_byte == WDRC_KEY_FIRST);
            if (key_seen && wr_byte == WDRC_KEY_SECOND) begin
               window_cnt <= 4'(WDRC_WINDOW_CLKS);
            end
         end else if (wr_stb || rd_stb) begin
            key_seen <= 1'b0; // any other access breaks the sequence
         end
      end
   end

   // plain registers; power and bus reset restore them
   // every reset source restores these, unlike the watchdog control byte
   always_ff @(posedge clk_i) begin
      if (rst_i || src_i.power_on || src_i.external || wd_reset_o) begin
         clock_control         <= WDRC_RST_CLOCK_CONTROL;
         extended_irq_enable   <= WDRC_RST_IRQ_ENABLE;
         extended_irq_priority <= WDRC_RST_IRQ_PRIORITY;
      end else if (wr_stb) begin
         if (adr_i == WDRC_ADDR_CLOCK_CONTROL) begin
            clock_control <= wr_byte;
         end else if (adr_i == WDRC_ADDR_IRQ_ENABLE) begin
            extended_irq_enable <= {3'b111, wr_byte[4:0]};
         end else if (adr_i == WDRC_ADDR_IRQ_PRIORITY) begin
            extended_irq_priority <= {3'b000, wr_byte[4:0]};
         end
      end
   end

   // watchdog control with per-source reset behaviour
   // priority: bus reset and power-on first, then external, then watchdog
   // protected bits only take writes inside the open window
   always_ff @(posedge clk_i) begin
      if (rst_i || src_i.power_on) begin
         // power-on: power flag set, enable and reset flag cleared
         watchdog_control <= 8'h00;
         watchdog_control[WDRC_BIT_POWER_FLAG] <= 1'b1;
      end else if (src_i.external) begin
         // keep bits 6,4,2,1; reset flag and enable retained
         watchdog_control <= watchdog_control & WDRC_EXT_RST_KEEP_MASK;
      end else if (wd_reset_o) begin
         // watchdog reset: like external, then flag set; enable kept
         watchdog_control <= watchdog_control & WDRC_EXT_RST_KEEP_MASK;
         watchdog_control[WDRC_BIT_RESET_FLAG] <= 1'b1;
      end else begin
         watchdog_control[WDRC_BIT_RESTART] <= 1'b0;
         if (wr_stb && adr_i == WDRC_ADDR_WD_CONTROL) begin
            watchdog_control[7] <= wr_byte[7];
            watchdog_control[5] <= wr_byte[5];
            watchdog_control[4] <= wr_byte[4];
            // reset flag is freely writable; software clears it
            watchdog_control[WDRC_BIT_RESET_FLAG] <= wr_byte[WDRC_BIT_RESET_FLAG];
            if (window_open) begin
               watchdog_control[WDRC_BIT_POWER_FLAG] <= wr_byte[WDRC_BIT_POWER_FLAG];
               watchdog_control[WDRC_BIT_IRQ_FLAG]   <= wr_byte[WDRC_BIT_IRQ_FLAG];
               watchdog_control[WDRC_BIT_RESET_EN]   <= wr_byte[WDRC_BIT_RESET_EN];
               watchdog_control[WDRC_BIT_RESTART]    <= wr_byte[WDRC_BIT_RESTART];
            end
         end
         // set wins over a clearing write
         if (timeout) begin
            watchdog_control[WDRC_BIT_IRQ_FLAG] <= 1'b1;
         end
      end
   end

   // watchdog count and delayed reset
   // a new timeout during the delay restarts the delay; the interval is
   // no shorter than the delay for a base exponent of 9 or more, so then this never starves the reset
   always_ff @(posedge clk_i) begin
      if (rst_i || src_i.power_on || src_i.external || wd_reset_o) begin
         wd_count  <= '0;
         delay_cnt <= 10'd0;
         delay_run <= 1'b0;
      end else if (watchdog_control[WDRC_BIT_RESTART]) begin
         wd_count  <= '0;
         delay_cnt <= 10'd0;
         delay_run <= 1'b0;
      end else begin
         wd_count <= wd_count + CNT_W'(1);
         if (timeout && watchdog_control[WDRC_BIT_RESET_EN]) begin
            delay_run <= 1'b1;
            delay_cnt <= 10'd0;
         end else if (delay_run) begin
            delay_cnt <= delay_cnt + 10'd1;
         end
      end
   end

   // forced reset pulse held two machine cycles; enable off means none
   // the enable is checked again at fire time so a late disable wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wd_reset_o <= 1'b0;
         hold_cnt   <= 4'h0;
      end else if (wd_fire && watchdog_control[WDRC_BIT_RESET_EN]) begin
         wd_reset_o <= 1'b1;
         hold_cnt   <= 4'(WDRC_RESET_HOLD_CLKS - 1);
      end else if (hold_cnt != 4'h0) begin
         hold_cnt <= hold_cnt - 4'h1;
      end else begin
         wd_reset_o <= 1'b0;
      end
   end

   // irq request and priority
   // both are registered so the outputs come straight from flip-flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wd_irq_o      <= 1'b0;
         wd_irq_high_o <= 1'b0;
      end else begin
         wd_irq_o <= watchdog_control[WDRC_BIT_IRQ_FLAG] &&
                     extended_irq_enable[WDRC_BIT_WD_IRQ];
         wd_irq_high_o <= extended_irq_priority[WDRC_BIT_WD_IRQ];
      end
   end

   // sticky event status, write one to clear; set wins
   // bit 0 marks a timeout, bit 1 a forced reset
   // the status survives the forced reset so software can inspect it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_status <= 2'b00;
         evt_mask   <= 2'b00;
         irq_o      <= 1'b0;
      end else begin
         if (wr_stb && adr_i == WDRC_ADDR_EVT_MASK) begin
            evt_mask <= wr_byte[1:0];
         end
         evt_status <= (evt_status &
                        ~((wr_stb && adr_i == WDRC_ADDR_EVT_STATUS) ? wr_byte[1:0] : 2'b00))
                       | {wd_fire && watchdog_control[WDRC_BIT_RESET_EN], timeout};
         irq_o <= |(evt_status & evt_mask);
      end
   end

   // read mux; unlock register reads zero, unmapped reads zero
   // read data is loaded on the take edge and stands while ack is high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd_stb) begin
         if (adr_i == WDRC_ADDR_CLOCK_CONTROL) begin
            dat_o <= {24'h000000, clock_control};
         end else if (adr_i == WDRC_ADDR_WD_CONTROL) begin
            dat_o <= {24'h000000, watchdog_control};
         end else if (adr_i == WDRC_ADDR_IRQ_ENABLE) begin
            dat_o <= {24'h000000, extended_irq_enable | 8'he0};
         end else if (adr_i == WDRC_ADDR_IRQ_PRIORITY) begin
            dat_o <= {24'h000000, extended_irq_priority};
         end else if (adr_i == WDRC_ADDR_EVT_STATUS) begin
            dat_o <= {30'h0, evt_status};
         end else if (adr_i == WDRC_ADDR_EVT_MASK) begin
            dat_o <= {30'h0, evt_mask};
         end else begin
            dat_o <= 32'h0000_0000;
         end
      end
   end

   // checks on the logic above
   // forced reset follows the end of the delay
   sequence s_fire;
      wd_fire && watchdog_control[WDRC_BIT_RESET_EN];
   endsequence
   property p_reset_after_fire;
      @(posedge clk_i) disable iff (rst_i) s_fire |=> wd_reset_o;
   endproperty
   a_reset_after_fire: assert property (p_reset_after_fire) else $error("no reset after delay");
   property p_no_reset_when_off;
      @(posedge clk_i) disable iff (rst_i)
         (!watchdog_control[WDRC_BIT_RESET_EN] && !wd_reset_o) |=> !$rose(wd_reset_o);
   endproperty
   a_no_reset_when_off: assert property (p_no_reset_when_off) else $error("reset while disabled");
   property p_flag_on_wd_reset;
      @(posedge clk_i) disable iff (rst_i || src_i.power_on || src_i.external)
         $rose(wd_reset_o) |=> watchdog_control[WDRC_BIT_RESET_FLAG];
   endproperty
   a_flag_on_wd_reset: assert property (p_flag_on_wd_reset) else $error("reset flag not set");
   property p_restart_clears;
      @(posedge clk_i) disable iff (rst_i) watchdog_control[WDRC_BIT_RESTART] |=> !watchdog_control[WDRC_BIT_RESTART];
   endproperty
   a_restart_clears: assert property (p_restart_clears) else $error("restart not self clearing");
   property p_por_values;
      @(posedge clk_i) src_i.power_on && !rst_i |=>
         watchdog_control[WDRC_BIT_POWER_FLAG] && !watchdog_control[WDRC_BIT_RESET_EN];
   endproperty
   a_por_values: assert property (p_por_values) else $error("power-on values wrong");
   property p_ext_keeps_flag;
      @(posedge clk_i) disable iff (rst_i || src_i.power_on)
         src_i.external |=> watchdog_control[WDRC_BIT_RESET_FLAG] == $past(watchdog_control[WDRC_BIT_RESET_FLAG]);
   endproperty
   a_ext_keeps_flag: assert property (p_ext_keeps_flag) else $error("external reset changed flag");
   property p_locked_enable;
      @(posedge clk_i) disable iff (rst_i || src_i.power_on || src_i.external || wd_reset_o)
         (wr_stb && adr_i == WDRC_ADDR_WD_CONTROL && !window_open) |=>
         watchdog_control[WDRC_BIT_RESET_EN] == $past(watchdog_control[WDRC_BIT_RESET_EN]);
   endproperty
   a_locked_enable: assert property (p_locked_enable) else $error("locked bit changed");
   property p_irq_flag_on_timeout;
      @(posedge clk_i) disable iff (rst_i || src_i.power_on || src_i.external || wd_reset_o)
         timeout |=> watchdog_control[WDRC_BIT_IRQ_FLAG];
   endproperty
   a_irq_flag_on_timeout: assert property (p_irq_flag_on_timeout) else $error("irq flag not set");
   property p_irq_gate;
      @(posedge clk_i) disable iff (rst_i) !extended_irq_enable[WDRC_BIT_WD_IRQ] |=> !wd_irq_o;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
   // window stays open twelve clocks, then shuts
   sequence s_window;
      window_open [*8] ##1 window_open [*4] ##1 !window_open;
   endsequence
   property p_window_len;
      @(posedge clk_i) disable iff (rst_i || wd_reset_o) $rose(window_open) |-> s_window;
   endproperty
   a_window_len: assert property (p_window_len) else $error("window length wrong");

   // forced reset stands for two machine cycles
   sequence s_hold;
      wd_reset_o [*8] ##1 !wd_reset_o;
   endsequence
   property p_hold_len;
      @(posedge clk_i) disable iff (rst_i) $rose(wd_reset_o) |-> s_hold;
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("reset hold wrong");

   // phase counter wraps after four states
   property p_mcycle_wrap;
      @(posedge clk_i) disable iff (rst_i) (mcycle == 2'd3) |=> (mcycle == 2'd0);
   endproperty
   a_mcycle_wrap: assert property (p_mcycle_wrap) else $error("phase did not wrap");

   // second key right after the first opens the window
   property p_unlock_opens;
      @(posedge clk_i) disable iff (rst_i || wd_reset_o)
         (wr_stb && adr_i == WDRC_ADDR_UNLOCK && key_seen && wr_byte == WDRC_KEY_SECOND)
         |=> window_open;
   endproperty
   a_unlock_opens: assert property (p_unlock_opens) else $error("window not opened");

   // armed timeout starts the delay
   property p_delay_start;
      @(posedge clk_i) disable iff (rst_i || src_i.power_on || src_i.external || wd_reset_o)
         (timeout && watchdog_control[WDRC_BIT_RESET_EN] &&
          !watchdog_control[WDRC_BIT_RESTART]) |=> delay_run;
   endproperty
   a_delay_start: assert property (p_delay_start) else $error("delay not started");

   // restart clears the count and cancels a pending reset
   property p_restart_cancels;
      @(posedge clk_i) disable iff (rst_i || src_i.power_on || src_i.external || wd_reset_o)
         watchdog_control[WDRC_BIT_RESTART] |=> (!delay_run && wd_count == '0);
   endproperty
   a_restart_cancels: assert property (p_restart_cancels) else $error("restart ignored");

   // external reset clears bits 7, 5, 3 and 0
   property p_ext_pattern;
      @(posedge clk_i) disable iff (rst_i || src_i.power_on)
         src_i.external |=> ((watchdog_control & 8'ha9) == 8'h00);
   endproperty
   a_ext_pattern: assert property (p_ext_pattern) else $error("external pattern wrong");

   // irq request follows flag and enable one cycle later
   property p_irq_req;
      @(posedge clk_i) disable iff (rst_i)
         1'b1 |=> (wd_irq_o == $past(watchdog_control[WDRC_BIT_IRQ_FLAG] &&
                                     extended_irq_enable[WDRC_BIT_WD_IRQ]));
   endproperty
   a_irq_req: assert property (p_irq_req) else $error("irq request wrong");

   // priority output follows the priority bit
   property p_irq_level;
      @(posedge clk_i) disable iff (rst_i)
         1'b1 |=> (wd_irq_high_o == $past(extended_irq_priority[WDRC_BIT_WD_IRQ]));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("priority output wrong");

   // event interrupt is high while an unmasked status bit is set
   property p_evt_irq;
      @(posedge clk_i) disable iff (rst_i)
         1'b1 |=> (irq_o == $past(|(evt_status & evt_mask)));
   endproperty
   a_evt_irq: assert property (p_evt_irq) else $error("event irq wrong");
endmodule : wdrc_top
`default_nettype wire

//--- bench/tb_watchdog_reset_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_reset_control;
   import wdrc_pkg::*;
   logic              clk_i;
   logic              rst_i;
   wdrc_rst_src_type  src_i;        // power-on / external reset requests
   logic              cyc_i, stb_i, we_i;
   logic [7:0]        adr_i;
   logic [3:0]        sel_i;        // only lane 0 carries data
   logic [31:0]       dat_i;
   logic [31:0]       dat_o;
   logic              ack_o, wd_irq_o, wd_irq_high_o, wd_reset_o, irq_o;
   logic [7:0]        exp_q[$];     // expected read data, oldest first
   logic [7:0]        msk_q[$];     // bits that carry meaning in each read
   logic [7:0]        mon_m;
   logic [7:0]        rnd;
   int                n_errors, num_checks, cnt;

   // short base interval keeps a timeout within a brief run
   wdrc_top #(.CNT_W(26), .IVL_BASE(10)) dut (.clk_i(clk_i), .rst_i(rst_i), .src_i(src_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .wd_irq_o(wd_irq_o), .wd_irq_high_o(wd_irq_high_o),
      .wd_reset_o(wd_reset_o), .irq_o(irq_o));

   // free-running 100 mhz clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // prints the counts and the verdict, then stops the run
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   // single comparison of a settled value
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // read data is judged here at the ack edge, against the oldest note
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0) begin
         if (exp_q.size() == 0) begin
            chk(8'hff, 8'h00);          // an answer nobody asked for
         end else begin
            mon_m = msk_q.pop_front();
            chk(dat_o[7:0] & mon_m, exp_q.pop_front());
         end
      end
   end

   // classic wishbone cycle; request held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] m);
      int i;
      if (!w) begin
         exp_q.push_back(d & m);
         msk_q.push_back(m);
      end
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= {24'h0, w ? d : 8'h00};
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack_o !== 1'b1 && i < 20);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (ack_o !== 1'b1) begin   // a slave that never answers ends the run
         n_errors++;
         end_of_test();
      end
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 8'hff);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      bus(1'b0, a, e, m);
   endtask : rd

   // the two key bytes back to back open the protected window
   task automatic unlock();
      wr(WDRC_ADDR_UNLOCK, WDRC_KEY_FIRST);
      wr(WDRC_ADDR_UNLOCK, WDRC_KEY_SECOND);
   endtask : unlock

   // let n edges pass, then look once their updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   // one reset source held for two machine cycles
   task automatic pulse_src(input logic pwr);
      @(posedge clk_i);
      if (pwr) src_i.power_on <= 1'b1;
      else     src_i.external <= 1'b1;
      repeat (8) @(posedge clk_i);
      src_i <= '0;
      tick(4);
   endtask : pulse_src

   // main sequence
   initial begin
      rst_i = 1'b1;
      src_i = '0;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i  = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'h1;
      dat_i = 32'h0;
      void'($urandom(32'h5dad));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      // reserved control bits 7,5,4 are masked out of every compare
      rd(WDRC_ADDR_WD_CONTROL, 8'h40, 8'h4f);
      rd(WDRC_ADDR_IRQ_ENABLE, 8'he0, 8'hf0);
      rd(WDRC_ADDR_CLOCK_CONTROL, WDRC_RST_CLOCK_CONTROL, 8'hff);
      rd(WDRC_ADDR_UNLOCK, 8'h00, 8'hff);
      wr(8'h10, 8'hff);
      rd(8'h10, 8'h00, 8'hff);
      $display("test reset_values done");
      // locked: only the reset flag takes the write
      wr(WDRC_ADDR_WD_CONTROL, 8'h0f);
      rd(WDRC_ADDR_WD_CONTROL, 8'h44, 8'h4f);
      wr(WDRC_ADDR_WD_CONTROL, 8'h00);
      rd(WDRC_ADDR_WD_CONTROL, 8'h40, 8'h4f);
      // another access between the keys must spoil the unlock
      wr(WDRC_ADDR_UNLOCK, WDRC_KEY_FIRST);
      rd(WDRC_ADDR_IRQ_ENABLE, 8'he0, 8'hf0);
      wr(WDRC_ADDR_UNLOCK, WDRC_KEY_SECOND);
      wr(WDRC_ADDR_WD_CONTROL, 8'h00);
      rd(WDRC_ADDR_WD_CONTROL, 8'h40, 8'h4f);
      // proper unlock: arm reset, restart count, restart bit clears itself
      unlock();
      wr(WDRC_ADDR_WD_CONTROL, 8'h03);
      rd(WDRC_ADDR_WD_CONTROL, 8'h02, 8'h4f);
      tick(20);
      wr(WDRC_ADDR_WD_CONTROL, 8'h00);
      rd(WDRC_ADDR_WD_CONTROL, 8'h02, 8'h4f);
      $display("test protection done");
      // random enable and priority bytes
      for (int k = 0; k < 4; k++) begin
         rnd = 8'($urandom());
         wr(WDRC_ADDR_IRQ_ENABLE, rnd);
         rd(WDRC_ADDR_IRQ_ENABLE, 8'he0 | (rnd & 8'h10), 8'hf0);
         wr(WDRC_ADDR_IRQ_PRIORITY, rnd);
         tick(2);
         chk({7'h0, wd_irq_high_o}, {7'h0, rnd[4]});
         chk({7'h0, wd_irq_o}, 8'h00);
      end
      $display("test enables done");
      // timeout with interrupt and reset both armed, event masked first
      wr(WDRC_ADDR_IRQ_ENABLE, 8'h10);
      wr(WDRC_ADDR_EVT_MASK, 8'h00);
      wr(WDRC_ADDR_CLOCK_CONTROL, 8'h01);
      cnt = 0;
      while (wd_irq_o !== 1'b1 && cnt < 4000) begin
         @(posedge clk_i);
         cnt++;
      end
      if (cnt >= 4000) begin
         n_errors++;
         end_of_test();
      end
      chk({7'h0, wd_reset_o}, 8'h00);
      fork
         begin
            cnt = 0;
            while (wd_reset_o !== 1'b1 && cnt < 1000) begin
               @(posedge clk_i);
               cnt++;
            end
            chk({7'h0, cnt >= 510 && cnt <= 514}, 8'h01);
            cnt = 0;
            while (wd_reset_o === 1'b1 && cnt < 20) begin
               @(posedge clk_i);
               cnt++;
            end
            chk(8'(cnt), 8'(WDRC_RESET_HOLD_CLKS));
         end
         begin
            rd(WDRC_ADDR_WD_CONTROL, 8'h0a, 8'h4f);
            tick(2);
            chk({7'h0, irq_o}, 8'h00);
            wr(WDRC_ADDR_EVT_MASK, 8'h01);
            tick(2);
            chk({7'h0, irq_o}, 8'h01);
            wr(WDRC_ADDR_EVT_STATUS, 8'h01);
            tick(2);
            chk({7'h0, irq_o}, 8'h00);
         end
      join
      tick(4);
      // watchdog reset: flag set, irq flag cleared, enable kept
      rd(WDRC_ADDR_WD_CONTROL, 8'h06, 8'h4f);
      rd(WDRC_ADDR_EVT_STATUS, 8'h02, 8'h03);
      wr(WDRC_ADDR_EVT_STATUS, 8'h03);
      $display("test timeout done");
      // external reset clears bits 3 and 0, keeps 6, 2 and 1
      wr(WDRC_ADDR_IRQ_ENABLE, 8'h10);
      unlock();
      wr(WDRC_ADDR_WD_CONTROL, 8'h4e);
      rd(WDRC_ADDR_WD_CONTROL, 8'h4e, 8'h4f);
      pulse_src(1'b0);
      rd(WDRC_ADDR_WD_CONTROL, 8'h46, 8'h4f);
      rd(WDRC_ADDR_IRQ_ENABLE, 8'he0, 8'hf0);
      $display("test external_reset done");
      // power-on reset drops the enable and the reset flag
      pulse_src(1'b1);
      rd(WDRC_ADDR_WD_CONTROL, 8'h40, 8'h4f);
      $display("test power_on done");
      tick(4);
      end_of_test();
   end
endmodule : tb_watchdog_reset_control
`default_nettype wire
